// file: hw/gvc_pkg.sv
package gvc_pkg;

// ==========================================================
// sizes and word map
localparam int unsigned NUM_GAMMA = 10;
localparam int unsigned NUM_WORDS = NUM_GAMMA + 4;
localparam logic [4:0] W_CMD = 5'h00;
localparam logic [4:0] W_LOW = 5'h01;
localparam logic [4:0] W_UP = 5'h02;
localparam logic [4:0] W_COM = 5'h03;
localparam logic [4:0] W_G0 = 5'h04;
localparam logic [4:0] W_LAST = 5'(NUM_WORDS - 1);
localparam logic [7:0] LAST_REG_ADDR = 8'(2 * NUM_WORDS - 1);
localparam logic [7:0] DUMMY_BYTE = 8'hff;

// ==========================================================
// link constants
localparam logic [6:0] SLAVE_ADDR = 7'h4f;
localparam logic [3:0] BITS_PER_BYTE = 4'h8;
localparam int unsigned SCL_MAX_KHZ = 400;

// ==========================================================
// command opcodes, written to the command word msb byte
localparam logic [7:0] OP_COM_STORE = 8'h01;
localparam logic [7:0] OP_COM_RECALL = 8'h02;
localparam logic [7:0] OP_GAM_STORE = 8'h03;
localparam logic [7:0] OP_GAM_RECALL = 8'h04;

// ==========================================================
// reset values and timing
localparam logic [9:0] RESET_CODE = 10'h000;
localparam logic [9:0] RESET_UPPER = 10'h3ff;
localparam int unsigned CORE_CLK_MHZ = 250;
localparam int unsigned POR_LOAD_US = 400;
localparam int unsigned POR_LOAD_CYC = POR_LOAD_US * CORE_CLK_MHZ;

// ==========================================================
// synchronised pin slots
localparam int PIN_SCL = 0;
localparam int PIN_SDA = 1;
localparam int PIN_TOG = 2;
localparam int PIN_SWB = 3;
localparam int PIN_SUP = 4;
localparam int NUM_PINS = 5;

// ==========================================================
// types
typedef enum logic [2:0] {
    I_IDLE, I_RX, I_ACK, I_TX, I_MACK, I_IGNORE
} gvc_ist_t;
typedef enum logic [1:0] {N_LOAD, N_IDLE, N_STORE, N_RECALL} gvc_nst_t;
typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA} gvc_kind_t;
typedef logic [NUM_WORDS-1:0][9:0] gvc_code_t;

typedef struct packed {
    logic req;
    logic we;
    logic [4:0] addr;
    logic [9:0] wdata;
} gvc_nv_req_t;

typedef struct packed {
    logic sbit;
    logic tog;
} gvc_link_t;

typedef struct packed {
    logic [NUM_PINS-1:0][2:0] sy;
    logic [NUM_PINS-1:0] flt;
    gvc_ist_t ist;
    gvc_kind_t kind;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rd;
    logic frame;
    logic sda_low;
    logic [7:0] ptr;
    logic [7:0] hold;
    logic hold_v;
    gvc_nst_t nst;
    logic [4:0] widx;
    logic [4:0] wlast;
    logic [16:0] wait_cnt;
    logic busy;
    gvc_nv_req_t nv;
    gvc_code_t code;
} gvc_state_t;

endpackage

// file: hw/gvc_control.sv
`timescale 1ns/1ps
`default_nettype none

module gvc_control
    import gvc_pkg::*;
#(
    parameter int unsigned LOAD_LIMIT_CYC = POR_LOAD_CYC
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic scl_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic sw_busy_i,
    input wire logic sw_up,
    input wire logic sw_dn,
    input wire logic sw_store,
    input wire logic prog_supply_ok,
    output gvc_nv_req_t nv_req,
    input wire logic nv_ready,
    input wire logic [9:0] nv_rdata,
    output logic i2c_busy,
    output logic [9:0] common_electrode_code,
    output logic [NUM_GAMMA-1:0][9:0] gamma_codes
);

// ==========================================================
// link domain: bit captured on each SCL rise, toggle marks it
gvc_link_t lk_r;
gvc_link_t lk_nxt;

always_comb begin
    lk_nxt = lk_r;
    lk_nxt.sbit = sda_i;
    lk_nxt.tog = ~lk_r.tog;
end

always_ff @(posedge scl_clk or negedge reset_n) begin
    if (!reset_n) begin
        lk_r <= '0;
    end else begin
        lk_r <= lk_nxt;
    end
end

// ==========================================================
// core domain
gvc_state_t r;
gvc_state_t n;
logic [NUM_PINS-1:0] pins;
logic scl_fall;
logic start_ev;
logic stop_ev;
logic bit_ev;
logic blocked;
logic [9:0] word_val;
logic [7:0] tx_byte;

assign pins = {prog_supply_ok, sw_busy_i, lk_r.tog, sda_i, scl_i};

function automatic logic [9:0] clamp(input logic [9:0] v,
                                     input logic [9:0] lo,
                                     input logic [9:0] hi);
    logic [9:0] o;
    o = v;
    if (v < lo) begin
        o = lo;
    end else if (v > hi) begin
        o = hi;
    end
    return o;
endfunction

function automatic logic [7:0] rd_byte(input logic [7:0] p,
                                       input gvc_code_t c);
    logic [7:0] o;
    o = DUMMY_BYTE;
    if (p <= LAST_REG_ADDR) begin
        if (p[0]) begin
            o = c[p[7:1]][7:0];
        end else begin
            o = {6'h00, c[p[7:1]][9:8]};
        end
    end
    return o;
endfunction

always_comb begin
    n = r;
    // three-stage sync; a level counts once stages two and three agree
    for (int i = 0; i < NUM_PINS; i++) begin
        n.sy[i] = {r.sy[i][1:0], pins[i]};
        if (r.sy[i][1] == r.sy[i][2]) begin
            n.flt[i] = r.sy[i][2];
        end
    end
    scl_fall = r.flt[PIN_SCL] & ~n.flt[PIN_SCL];
    start_ev = r.flt[PIN_SCL] & n.flt[PIN_SCL]
               & r.flt[PIN_SDA] & ~n.flt[PIN_SDA];
    stop_ev = r.flt[PIN_SCL] & n.flt[PIN_SCL]
              & ~r.flt[PIN_SDA] & n.flt[PIN_SDA];
    // sbit is held for a full SCL period, far longer than the sync delay
    bit_ev = r.flt[PIN_TOG] != n.flt[PIN_TOG];
    blocked = (r.nst != N_IDLE) | r.flt[PIN_SWB];
    word_val = {r.hold[1:0], r.sh};
    tx_byte = rd_byte(r.ptr, r.code);

    // ======================================================
    // nonvolatile transfer engine, one word per handshake
    unique case (r.nst)
        N_LOAD: begin
            n.wait_cnt = r.wait_cnt + 17'h00001;
            if (r.nv.req && nv_ready) begin
                n.code[r.widx] = nv_rdata;
                n.widx = r.widx + 5'h01;
                if (r.widx == r.wlast) begin
                    n.nst = N_IDLE;
                end
            end
            // a dead store must not lock the link out forever
            if (r.wait_cnt == 17'(LOAD_LIMIT_CYC - 1)) begin
                n.nst = N_IDLE;
            end
        end
        N_STORE: begin
            if (nv_ready) begin
                n.widx = r.widx + 5'h01;
                if (r.widx == r.wlast) begin
                    n.nst = N_IDLE;
                end
            end
        end
        N_RECALL: begin
            if (nv_ready) begin
                n.code[r.widx] = nv_rdata;
                n.widx = r.widx + 5'h01;
                if (r.widx == r.wlast) begin
                    n.nst = N_IDLE;
                end
            end
        end
        N_IDLE: begin
        end
    endcase

    // ======================================================
    // link slave
    if (stop_ev) begin
        n.ist = I_IDLE;
        n.frame = 1'b0;
        n.sda_low = 1'b0;
        n.hold_v = 1'b0;
    end else if (start_ev) begin
        n.ist = I_RX;
        n.kind = K_ADDR;
        n.cnt = 4'h0;
        n.sda_low = 1'b0;
        n.hold_v = 1'b0;
    end else begin
        unique case (r.ist)
            I_RX: begin
                if (bit_ev) begin
                    n.sh = {r.sh[6:0], lk_r.sbit};
                    n.cnt = r.cnt + 4'h1;
                end
                if (scl_fall && r.cnt == BITS_PER_BYTE) begin
                    if (blocked) begin
                        n.ist = I_IGNORE;
                    end else if (r.kind == K_ADDR) begin
                        if (r.sh[7:1] == SLAVE_ADDR) begin
                            n.rd = r.sh[0];
                            n.kind = K_PTR;
                            n.frame = 1'b1;
                            n.ist = I_ACK;
                            n.sda_low = 1'b1;
                        end else begin
                            n.ist = I_IGNORE;
                        end
                    end else begin
                        n.ist = I_ACK;
                        n.sda_low = 1'b1;
                        if (r.kind == K_PTR) begin
                            n.ptr = r.sh;
                            n.kind = K_DATA;
                        end else begin
                            n.ptr = r.ptr + 8'h01;
                            if (!r.ptr[0]) begin
                                n.hold = r.sh;
                                n.hold_v = r.ptr <= LAST_REG_ADDR;
                            end else if (r.hold_v) begin
                                n.hold_v = 1'b0;
                                if (r.ptr[7:1] == 7'(W_COM)) begin
                                    n.code[W_COM] = clamp(word_val,
                                        r.code[W_LOW],
                                        r.code[W_UP]);
                                end else begin
                                    n.code[r.ptr[7:1]] = word_val;
                                end
                                if (r.ptr[7:1] == 7'(W_CMD)) begin
                                    n.widx = W_COM;
                                    n.wlast = W_COM;
                                    if (r.hold == OP_GAM_STORE
                                        || r.hold == OP_GAM_RECALL) begin
                                        n.widx = W_G0;
                                        n.wlast = W_LAST;
                                    end
                                    if (r.hold == OP_COM_RECALL
                                        || r.hold == OP_GAM_RECALL) begin
                                        n.nst = N_RECALL;
                                    end
                                    if ((r.hold == OP_COM_STORE
                                        || r.hold == OP_GAM_STORE)
                                        && r.flt[PIN_SUP]) begin
                                        n.nst = N_STORE;
                                    end
                                end
                            end
                        end
                    end
                end
            end
            I_ACK, I_MACK: begin
                if (bit_ev) begin
                    n.sh = {r.sh[6:0], lk_r.sbit};
                end
                if (scl_fall) begin
                    n.sda_low = 1'b0;
                    n.cnt = 4'h0;
                    n.ist = I_RX;
                    if (r.rd && r.ist == I_MACK && r.sh[0]) begin
                        n.ist = I_IGNORE;
                    end else if (r.rd) begin
                        n.ist = I_TX;
                        n.sda_low = ~tx_byte[7];
                        n.sh = {tx_byte[6:0], 1'b0};
                        n.cnt = 4'h1;
                        n.ptr = r.ptr + 8'h01;
                    end
                end
            end
            I_TX: begin
                if (scl_fall) begin
                    if (r.cnt == BITS_PER_BYTE) begin
                        n.sda_low = 1'b0;
                        n.ist = I_MACK;
                    end else begin
                        n.sda_low = ~r.sh[7];
                        n.sh = {r.sh[6:0], 1'b0};
                        n.cnt = r.cnt + 4'h1;
                    end
                end
            end
            I_IDLE, I_IGNORE: begin
            end
        endcase
    end

    // ======================================================
    // single-wire requests, dropped while the link or store is busy
    if (!r.busy && r.nst == N_IDLE) begin
        if (sw_up) begin
            n.code[W_COM] = clamp((r.code[W_COM] == 10'h3ff) ? 10'h3ff
                : r.code[W_COM] + 10'h001, r.code[W_LOW],
                r.code[W_UP]);
        end else if (sw_dn) begin
            n.code[W_COM] = clamp((r.code[W_COM] == 10'h000) ? 10'h000
                : r.code[W_COM] - 10'h001, r.code[W_LOW],
                r.code[W_UP]);
        end else if (sw_store && r.flt[PIN_SUP]) begin
            n.nst = N_STORE;
            n.widx = W_COM;
            n.wlast = W_COM;
        end
    end

    n.busy = n.frame | (n.nst != N_IDLE);
    n.nv.req = n.nst != N_IDLE;
    n.nv.we = n.nst == N_STORE;
    n.nv.addr = n.widx - 5'h01;
    n.nv.wdata = n.code[n.widx];
end

always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        r <= '{sy: '1, flt: '1, ist: I_IDLE, kind: K_ADDR, cnt: 4'h0,
               sh: 8'h00, rd: 1'b0, frame: 1'b0, sda_low: 1'b0,
               ptr: 8'h00, hold: 8'h00, hold_v: 1'b0, nst: N_LOAD,
               widx: W_LOW, wlast: W_LAST, wait_cnt: 17'h00000,
               busy: 1'b1, nv: '{req: 1'b1, we: 1'b0, addr: 5'h00,
               wdata: 10'h000}, code: '{W_UP: RESET_UPPER,
               default: RESET_CODE}};
    end else begin
        r <= n;
    end
end

// ==========================================================
// outputs
assign sda_o = 1'b0;
assign sda_oe_n = ~r.sda_low;
assign nv_req = r.nv;
assign i2c_busy = r.busy;
assign common_electrode_code = r.code[W_COM];

genvar g;
generate
    for (g = 0; g < NUM_GAMMA; g++) begin : gen_gamma
        assign gamma_codes[g] = r.code[W_G0 + 5'(g)];
    end
endgenerate

// ==========================================================
// checks
property p_load_nak;
    @(posedge core_clk) disable iff (!reset_n)
    (r.nst == N_LOAD) |-> !r.sda_low;
endproperty
a_load_nak: assert property (p_load_nak)
    else $error("acknowledge during power-up load");

property p_load_bound;
    @(posedge core_clk) disable iff (!reset_n)
    (r.nst == N_LOAD) |-> (r.wait_cnt < 17'(LOAD_LIMIT_CYC));
endproperty
a_load_bound: assert property (p_load_bound)
    else $error("power-up load overran its limit");

property p_swb_nak;
    @(posedge core_clk) disable iff (!reset_n)
    ($rose(r.sda_low) && r.ist == I_ACK) |-> !$past(r.flt[PIN_SWB]);
endproperty
a_swb_nak: assert property (p_swb_nak)
    else $error("acknowledge while single-wire busy");

property p_sw_ignored;
    @(posedge core_clk) disable iff (!reset_n)
    ((sw_up || sw_dn) && r.nst == N_STORE) |=> $stable(r.code[W_COM]);
endproperty
a_sw_ignored: assert property (p_sw_ignored)
    else $error("single-wire change during store");

property p_gamma_no_sw;
    @(posedge core_clk) disable iff (!reset_n)
    ((sw_up || sw_dn || sw_store) && r.ist == I_IDLE
        && r.nst == N_IDLE) |=> $stable(r.code[W_LAST:W_G0]);
endproperty
a_gamma_no_sw: assert property (p_gamma_no_sw)
    else $error("single-wire touched gamma codes");

property p_clamp_low;
    @(posedge core_clk) disable iff (!reset_n)
    (sw_dn && !r.busy && r.nst == N_IDLE && !sw_up
        && r.code[W_COM] <= r.code[W_LOW])
        |=> r.code[W_COM] == $past(r.code[W_LOW]);
endproperty
a_clamp_low: assert property (p_clamp_low)
    else $error("common code below lower limit");

property p_clamp_high;
    @(posedge core_clk) disable iff (!reset_n)
    (sw_up && !r.busy && r.nst == N_IDLE
        && r.code[W_COM] >= r.code[W_UP]
        && r.code[W_UP] >= r.code[W_LOW])
        |=> r.code[W_COM] == $past(r.code[W_UP]);
endproperty
a_clamp_high: assert property (p_clamp_high)
    else $error("common code above upper limit");

property p_single_discard;
    @(posedge core_clk) disable iff (!reset_n)
    ($fell(r.hold_v) && r.ist == I_IDLE) |-> $stable(r.code);
endproperty
a_single_discard: assert property (p_single_discard)
    else $error("lone byte changed a register");

property p_ack_hold;
    @(posedge core_clk) disable iff (!reset_n)
    ($rose(r.sda_low) && r.ist == I_ACK)
        |-> ##1 (r.ist == I_ACK && r.sda_low) [*8];
endproperty
a_ack_hold: assert property (p_ack_hold)
    else $error("acknowledge released early");

property p_prog_nak;
    @(posedge core_clk) disable iff (!reset_n)
    (r.nst == N_STORE && r.ist != I_ACK) |-> !r.sda_low;
endproperty
a_prog_nak: assert property (p_prog_nak)
    else $error("acknowledge during programming");

property p_supply_gate;
    @(posedge core_clk) disable iff (!reset_n)
    (r.nst == N_STORE && $past(r.nst) == N_IDLE)
        |-> $past(r.flt[PIN_SUP]);
endproperty
a_supply_gate: assert property (p_supply_gate)
    else $error("programming started on low supply");

property p_ptr_inc;
    @(posedge core_clk) disable iff (!reset_n)
    (r.ist == I_ACK && $past(r.ist) == I_RX && $past(r.kind) == K_DATA)
        |-> r.ptr == 8'($past(r.ptr) + 8'h01);
endproperty
a_ptr_inc: assert property (p_ptr_inc)
    else $error("pointer did not advance");

c_store: cover property (@(posedge core_clk) disable iff (!reset_n)
    r.nst == N_IDLE ##1 r.nst == N_STORE);
c_recall: cover property (@(posedge core_clk) disable iff (!reset_n)
    r.nst == N_IDLE ##1 r.nst == N_RECALL);
c_read: cover property (@(posedge core_clk) disable iff (!reset_n)
    r.ist == I_MACK ##1 r.ist == I_TX);

endmodule

`default_nettype wire

// file: tb/gvc_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// bus master model; scl stands high between frames
module gvc_i2c_master (
    output logic scl,
    output logic sda_drv,
    input wire logic sda
);
    localparam real Q = 16.0;

    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic bit_io(input logic b, output logic r);
        #Q sda_drv = b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
    endtask

    // small offset keeps scl off the core clock phase
    task automatic start();
        #(Q + 0.3) sda_drv = 1'b1;
        #Q scl = 1'b1;
        #Q sda_drv = 1'b0;
        #Q scl = 1'b0;
    endtask

    task automatic stop();
        #Q sda_drv = 1'b0;
        #Q scl = 1'b1;
        #Q sda_drv = 1'b1;
    endtask

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, r);
    endtask
endmodule

`default_nettype wire

// file: tb/tb_gvc_control.sv
`timescale 1ns/1ps
`default_nettype none

module tb_gvc_control import gvc_pkg::*;;
    localparam logic [9:0] LO = 10'h040;
    localparam logic [9:0] HI = 10'h380;
    logic core_clk, reset_n, sw_busy_i, sw_up, sw_dn, sw_store, sup_ok;
    logic nv_ready = 1'b0;
    logic [9:0] nv_rdata = 10'h000;
    logic sda_o, sda_oe_n, i2c_busy;
    logic [9:0] com;
    logic [NUM_GAMMA-1:0][9:0] gam;
    gvc_nv_req_t nv_req;
    wire logic scl;
    wire logic m_sda;
    // open drain with pull-up: wire is low if anyone pulls
    wire logic sda = m_sda & (sda_oe_n | sda_o);
    logic [9:0] nv_mem [0:12];
    logic [7:0] q[$];
    int nv_dly, wt, miscompares, num_checks;

    gvc_control #(.LOAD_LIMIT_CYC(1000)) u_dut (
        .core_clk(core_clk), .reset_n(reset_n), .scl_clk(scl),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .sw_busy_i(sw_busy_i), .sw_up(sw_up), .sw_dn(sw_dn),
        .sw_store(sw_store), .prog_supply_ok(sup_ok), .nv_req(nv_req),
        .nv_ready(nv_ready), .nv_rdata(nv_rdata), .i2c_busy(i2c_busy),
        .common_electrode_code(com), .gamma_codes(gam)
    );
    gvc_i2c_master u_mst (.scl(scl), .sda_drv(m_sda), .sda(sda));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // ==========================================================
    // store model; read data scrambled outside its ready cycle
    always @(negedge core_clk) begin
        nv_rdata <= ~nv_rdata;
        if (!reset_n || !nv_req.req || nv_ready) begin
            nv_ready <= 1'b0;
            wt <= 0;
        end else if (wt >= nv_dly) begin
            nv_ready <= 1'b1;
            nv_rdata <= nv_mem[nv_req.addr];
            if (nv_req.we) nv_mem[nv_req.addr] <= nv_req.wdata;
        end else begin
            wt <= wt + 1;
        end
    end

    // ==========================================================
    // helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    function automatic logic [9:0] clamp(input logic [9:0] v);
        return (v < LO) ? LO : ((v > HI) ? HI : v);
    endfunction

    task automatic put(input logic [9:0] v);
        q.push_back({6'h00, v[9:8]});
        q.push_back(v[7:0]);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] ptr,
                      input logic ok);
        logic a;
        u_mst.start();
        u_mst.wbyte(adr, a);
        check(a, ok);
        if (ok) begin
            u_mst.wbyte(ptr, a);
            check(a, 1'b1);
            foreach (q[i]) begin
                u_mst.wbyte(q[i], a);
                check(a, 1'b1);
            end
        end
        u_mst.stop();
    endtask

    task automatic rd(input logic [7:0] ptr);
        logic a;
        logic [7:0] d;
        u_mst.start();
        u_mst.wbyte(8'h9e, a);
        u_mst.wbyte(ptr, a);
        u_mst.start();
        u_mst.wbyte(8'h9f, a);
        check(a, 1'b1);
        foreach (q[i]) begin
            u_mst.rbyte(i == q.size() - 1, d);
            check(d, q[i]);
        end
        u_mst.stop();
    endtask

    task automatic set_com(input logic [9:0] v);
        q = {};
        put(v);
        wr(8'h9e, 8'h06, 1'b1);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (i2c_busy !== 1'b0 && n < 20000) begin
            @(negedge core_clk);
            n++;
        end
        check(i2c_busy, 1'b0);
    endtask

    task automatic pulse(ref logic s);
        // a just-seen stop needs a few cycles to clear busy
        repeat (8) @(negedge core_clk);
        s = 1'b1;
        @(negedge core_clk);
        s = 1'b0;
        repeat (8) @(negedge core_clk);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        int v;
        logic a;
        logic [9:0] keep;
        reset_n = 1'b0;
        {sw_busy_i, sw_up, sw_dn, sw_store} = 4'h0;
        sup_ok = 1'b1;
        miscompares = 0;
        num_checks = 0;
        nv_dly = 30;
        void'($urandom(44));
        nv_mem[0] = LO;
        nv_mem[1] = HI;
        for (int i = 2; i < 13; i++) nv_mem[i] = 10'($urandom_range(1023, 0));
        repeat (8) @(negedge core_clk);
        reset_n = 1'b1;
        q = {};
        wr(8'h9e, 8'h00, 1'b0);
        wait_idle();
        nv_dly = 2;
        check(com, nv_mem[2]);
        for (int i = 0; i < 10; i++) check(gam[i], nv_mem[i + 3]);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 0 : (i == 1) ? 1023 : $urandom_range(1023, 0);
            set_com(v[9:0]);
            check(com, clamp(v[9:0]));
            q = {};
            put(clamp(v[9:0]));
            rd(8'h06);
        end
        keep = clamp(v[9:0]);
        q = {8'h01};
        wr(8'h9e, 8'h06, 1'b1);
        check(com, keep);
        u_mst.start();
        u_mst.wbyte(8'h9e, a);
        u_mst.wbyte(8'h06, a);
        u_mst.wbyte(8'h02, a);
        repeat (4) u_mst.bit_io(1'b0, a);
        u_mst.stop();
        check(com, keep);
        v = $urandom_range(1023, 0);
        keep = 10'($urandom_range(1023, 0));
        q = {};
        put(v[9:0]);
        put(keep);
        wr(8'h9e, 8'h08, 1'b1);
        check(gam[0], v[9:0]);
        check(gam[1], keep);
        rd(8'h08);
        q = {8'hff, 8'hff};
        rd(8'h1c);
        q = {};
        wr(8'h90, 8'h00, 1'b0);
        // slow store so the busy window spans a whole probe frame
        nv_dly = 300;
        for (int op = 1; op <= 4; op++) begin
            if (op % 2 == 0) begin
                for (int i = 2; i < 13; i++) nv_mem[i] = 10'($urandom);
            end
            q = {8'(op), 8'h00};
            wr(8'h9e, 8'h00, 1'b1);
            q = {};
            wr(8'h9e, 8'h00, 1'b0);
            wait_idle();
            for (int i = 2; i < 13; i++) begin
                if (i == 2 && op < 3) check(com, nv_mem[2]);
                if (i > 2 && op > 2) check(gam[i - 3], nv_mem[i]);
            end
        end
        nv_dly = 2;
        @(negedge core_clk) sup_ok = 1'b0;
        keep = nv_mem[2];
        set_com(10'h100);
        check(com, 10'h100);
        q = {OP_COM_STORE, 8'h00};
        wr(8'h9e, 8'h00, 1'b1);
        wait_idle();
        check(nv_mem[2], keep);
        @(negedge core_clk) sup_ok = 1'b1;
        @(negedge core_clk) sw_busy_i = 1'b1;
        q = {};
        wr(8'h9e, 8'h00, 1'b0);
        @(negedge core_clk) sw_busy_i = 1'b0;
        keep = nv_mem[3];
        set_com(HI - 10'h001);
        pulse(sw_up);
        check(com, HI);
        pulse(sw_up);
        check(com, HI);
        set_com(LO);
        pulse(sw_dn);
        check(com, LO);
        nv_dly = 300;
        pulse(sw_store);
        pulse(sw_up);
        check(com, LO);
        wait_idle();
        check(nv_mem[2], LO);
        check(gam[0], keep);
        u_mst.start();
        u_mst.wbyte(8'h9e, a);
        pulse(sw_up);
        u_mst.stop();
        check(com, LO);
        finish_test();
    end

    initial begin
        #350000;
        miscompares++;
        finish_test();
    end
endmodule

`default_nettype wire
